// ### mcr_pkg.sv
// constants for the metering configuration register bank
package mcr_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] CORE_CONFIGURATION_ADDR = 10'h102;
    localparam logic [DATA_W-1:0] CORE_CONFIGURATION_RST = 16'h8004;
    // bits that hold state; soft reset and reserved bit are not stored
    localparam logic [DATA_W-1:0] CORE_CONFIGURATION_MASK = 16'hBF7F;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 16'h0000;

    localparam int INT_A_BIT = 0;
    localparam int INT_B_BIT = 1;
    localparam int HPF_BIT = 2;
    localparam int PF_SRC_BIT = 3;
    localparam int REV_PICK_BIT = 4;
    localparam int REV_BLINK_BIT = 5;
    localparam int ZX_FILT_OFF_BIT = 6;
    localparam int SOFT_RST_BIT = 7;
    localparam int CHECKSUM_BIT = 8;
    localparam int PWR_FILT_LSB = 9;
    localparam int PWR_FILT_MSB = 10;
    localparam int ZX_SRC_BIT = 11;
    localparam int ZERO_CROSS_EDGE_PICK_LSB = 12;
    localparam int ZERO_CROSS_EDGE_PICK_MSB = 13;
    localparam int RESERVED_BIT = 14;
    localparam int LOCK_OFF_BIT = 15;

    // power filter time constants by code, in milliseconds
    localparam int PWR_FILT_MS_0 = 250;
    localparam int PWR_FILT_MS_1 = 500;
    localparam int PWR_FILT_MS_2 = 1000;
    localparam int PWR_FILT_MS_3 = 2000;

    // zero crossing edge codes
    localparam logic [1:0] ZERO_CROSS_EDGE_PICK_NEG_ONLY = 2'h1;
    localparam logic [1:0] ZERO_CROSS_EDGE_PICK_POS_ONLY = 2'h2;

    // reverse power blink: 1 Hz at a 40 ns clock
    localparam int CLK_PERIOD_NS = 40;
    localparam int BLINK_PERIOD_MS = 1000;
    localparam int BLINK_PERIOD_CYC = BLINK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
endpackage

// ### mcr_config_reg.sv
// configuration register bank of the metering core with its side effects
// Contract
// - bits 0,1 enable channel A/B integrators
// - bit 2 enables high-pass filter, resets one
// - bit 3 picks power factor source
// - bits 4,5 steer reverse-power output
// - bit 6 one bypasses zero-cross filter
// - writing bit 7 triggers soft reset
// - bit 8 enables checksum, default off
// - bits 10:9 pick power filter time
// - bit 11 picks current zero-cross channel
// - bits 13:12 pick zero-cross interrupt edge
// - bit 15 zero enables interface lock
`timescale 1ns/1ps
`default_nettype none
module mcr_config_reg
    import mcr_pkg::*;
#(
    parameter int BLINK_CYC = BLINK_PERIOD_CYC
)
(
    input wire logic ref_clk_i,                          // core clock
    input wire logic nrst_i,                             // sync reset, active low
    input wire logic ce_i,                               // clock enable
    input wire logic wr_en_i,                            // register write strobe
    input wire logic rd_en_i,                            // register read strobe
    input wire logic [mcr_pkg::ADDR_W-1:0] addr_i,       // register address
    input wire logic [mcr_pkg::DATA_W-1:0] wdata_i,      // write data
    input wire logic pulse_output_one_i,                 // first pulse output event
    input wire logic pulse_output_two_i,                 // second pulse output event
    input wire logic reverse_polarity_i,                 // power sign is reverse
    input wire logic zx_pos_a_i,                         // chan A rising crossing
    input wire logic zx_neg_a_i,                         // chan A falling crossing
    input wire logic zx_pos_b_i,                         // chan B rising crossing
    input wire logic zx_neg_b_i,                         // chan B falling crossing
    output logic [mcr_pkg::DATA_W-1:0] rdata_o,          // read data
    output logic rd_valid_o,                             // read data valid pulse
    output logic integrator_on_chan_a_o,                 // chan A integrator on
    output logic integrator_on_chan_b_o,                 // chan B integrator on
    output logic highpass_on_o,                          // high-pass filter on
    output logic power_factor_source_o,                  // 1: line-cycle energies
    output logic zero_cross_filter_off_o,                // zero-cross filter bypass
    output logic checksum_on_o,                          // checksum enabled
    output logic [1:0] power_filter_time_o,              // power filter code
    output logic current_zero_cross_source_o,            // 1: chan B
    output logic interface_lock_off_o,                   // 1: lock disabled
    output logic soft_reset_o,                           // soft reset pulse
    output logic reverse_power_out_o,                    // reverse power pin level
    output logic zero_cross_irq_o                        // zero-cross interrupt pulse
);
    import mcr_pkg::*;

    localparam int BLINK_W = $clog2(BLINK_CYC);
    localparam logic [BLINK_W-1:0] BLINK_HALF = BLINK_W'(BLINK_CYC / 2 - 1);

    // blink needs two equal halves of at least two cycles each
    if (BLINK_CYC < 4 || BLINK_CYC % 2 != 0)
    begin : g_bad_blink
        $error("BLINK_CYC must be even and at least 4");
    end

    logic [DATA_W-1:0] cfg_r;
    logic [DATA_W-1:0] rdata_r;
    logic rd_valid_r;
    logic soft_reset_r;
    logic rev_state_r;
    logic blink_phase_r;
    logic [BLINK_W-1:0] blink_cnt_r;
    logic rev_out_r;
    logic zx_irq_r;
    logic hit;
    logic wr_hit;
    logic soft_req;
    logic pick_pulse;
    logic zx_pos;
    logic zx_neg;
    logic [1:0] zero_cross_edge_pick;

    assign hit = (addr_i == CORE_CONFIGURATION_ADDR);
    assign wr_hit = ce_i & wr_en_i & hit;
    assign soft_req = wr_hit & wdata_i[SOFT_RST_BIT];
    assign pick_pulse = cfg_r[REV_PICK_BIT] ? pulse_output_two_i : pulse_output_one_i;
    assign zx_pos = cfg_r[ZX_SRC_BIT] ? zx_pos_b_i : zx_pos_a_i;
    assign zx_neg = cfg_r[ZX_SRC_BIT] ? zx_neg_b_i : zx_neg_a_i;
    assign zero_cross_edge_pick = cfg_r[ZERO_CROSS_EDGE_PICK_MSB:ZERO_CROSS_EDGE_PICK_LSB];

    // configuration storage
    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            cfg_r <= CORE_CONFIGURATION_RST;
        end
        else if (soft_req)
        begin
            cfg_r <= CORE_CONFIGURATION_RST;
        end
        else if (wr_hit)
        begin
            cfg_r <= wdata_i & CORE_CONFIGURATION_MASK;
        end
    end

    // soft reset pulse toward the rest of the device
    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            soft_reset_r <= 1'b0;
        end
        else if (ce_i)
        begin
            soft_reset_r <= soft_req;
        end
    end

    // read port; unmapped addresses return zero
    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            rdata_r <= UNMAPPED_READ;
            rd_valid_r <= 1'b0;
        end
        else if (ce_i)
        begin
            rd_valid_r <= rd_en_i;
            if (rd_en_i && hit)
            begin
                rdata_r <= cfg_r;
            end
            else
            begin
                rdata_r <= UNMAPPED_READ;
            end
        end
    end

    // reverse status sampled on the chosen pulse output
    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            rev_state_r <= 1'b0;
        end
        else if (ce_i && pick_pulse)
        begin
            rev_state_r <= reverse_polarity_i;
        end
    end

    // 1 Hz blink, high half first, held idle while not reverse
    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            blink_cnt_r <= '0;
            blink_phase_r <= 1'b1;
        end
        else if (ce_i)
        begin
            if (!rev_state_r)
            begin
                blink_cnt_r <= '0;
                blink_phase_r <= 1'b1;
            end
            else if (blink_cnt_r == BLINK_HALF)
            begin
                blink_cnt_r <= '0;
                blink_phase_r <= ~blink_phase_r;
            end
            else
            begin
                blink_cnt_r <= blink_cnt_r + 1'b1;
            end
        end
    end

    // reverse power pin
    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            rev_out_r <= 1'b0;
        end
        else if (ce_i)
        begin
            if (cfg_r[REV_BLINK_BIT])
            begin
                rev_out_r <= rev_state_r & blink_phase_r;
            end
            else
            begin
                rev_out_r <= rev_state_r;
            end
        end
    end

    // zero-cross interrupt by source and edge selection
    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            zx_irq_r <= 1'b0;
        end
        else if (ce_i)
        begin
            zx_irq_r <= (zx_pos && zero_cross_edge_pick != ZERO_CROSS_EDGE_PICK_NEG_ONLY)
                || (zx_neg && zero_cross_edge_pick != ZERO_CROSS_EDGE_PICK_POS_ONLY);
        end
    end

    assign rdata_o = rdata_r;
    assign rd_valid_o = rd_valid_r;
    assign integrator_on_chan_a_o = cfg_r[INT_A_BIT];
    assign integrator_on_chan_b_o = cfg_r[INT_B_BIT];
    assign highpass_on_o = cfg_r[HPF_BIT];
    assign power_factor_source_o = cfg_r[PF_SRC_BIT];
    assign zero_cross_filter_off_o = cfg_r[ZX_FILT_OFF_BIT];
    assign checksum_on_o = cfg_r[CHECKSUM_BIT];
    assign power_filter_time_o = cfg_r[PWR_FILT_MSB:PWR_FILT_LSB];
    assign current_zero_cross_source_o = cfg_r[ZX_SRC_BIT];
    assign interface_lock_off_o = cfg_r[LOCK_OFF_BIT];
    assign soft_reset_o = soft_reset_r;
    assign reverse_power_out_o = rev_out_r;
    assign zero_cross_irq_o = zx_irq_r;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!nrst_i);

    logic plain_wr;
    assign plain_wr = wr_hit & ~wdata_i[SOFT_RST_BIT];

    sequence s_plain_write;
        plain_wr;
    endsequence

    property p_integrators;
        s_plain_write |=> integrator_on_chan_a_o == $past(wdata_i[INT_A_BIT])
            && integrator_on_chan_b_o == $past(wdata_i[INT_B_BIT]);
    endproperty
    a_integrators: assert property (p_integrators) else $error("integrator bits wrong");

    property p_hpf_after_reset;
        $past(!nrst_i) |-> highpass_on_o && !integrator_on_chan_a_o;
    endproperty
    a_hpf_after_reset: assert property (p_hpf_after_reset) else $error("hpf not on at reset");

    property p_pf_source;
        s_plain_write |=> power_factor_source_o == $past(wdata_i[PF_SRC_BIT]);
    endproperty
    a_pf_source: assert property (p_pf_source) else $error("pf source not stored");

    property p_rev_low;
        ce_i && !rev_state_r |=> !reverse_power_out_o;
    endproperty
    a_rev_low: assert property (p_rev_low) else $error("reverse output not low");

    property p_rev_level;
        ce_i && !cfg_r[REV_BLINK_BIT] |=> reverse_power_out_o == $past(rev_state_r);
    endproperty
    a_rev_level: assert property (p_rev_level) else $error("reverse level wrong");

    property p_zx_filter;
        s_plain_write |=> zero_cross_filter_off_o == $past(wdata_i[ZX_FILT_OFF_BIT]);
    endproperty
    a_zx_filter: assert property (p_zx_filter) else $error("zx filter bit wrong");

    sequence s_soft_done;
        soft_reset_o && cfg_r == CORE_CONFIGURATION_RST;
    endsequence

    property p_soft_reset;
        soft_req |=> s_soft_done;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset not done");

    property p_checksum_default;
        $past(!nrst_i) |-> !checksum_on_o && interface_lock_off_o;
    endproperty
    a_checksum_default: assert property (p_checksum_default) else $error("bad defaults");

    property p_filter_time;
        s_plain_write |=> power_filter_time_o == $past(wdata_i[PWR_FILT_MSB:PWR_FILT_LSB]);
    endproperty
    a_filter_time: assert property (p_filter_time) else $error("filter time wrong");

    property p_zx_neg_only;
        ce_i && zero_cross_edge_pick == ZERO_CROSS_EDGE_PICK_NEG_ONLY && !zx_neg |=> !zero_cross_irq_o;
    endproperty
    a_zx_neg_only: assert property (p_zx_neg_only) else $error("zx irq on wrong edge");

    property p_zx_source;
        ce_i && current_zero_cross_source_o && zx_pos_b_i && zero_cross_edge_pick != ZERO_CROSS_EDGE_PICK_NEG_ONLY
            |=> zero_cross_irq_o;
    endproperty
    a_zx_source: assert property (p_zx_source) else $error("zx source B missed");

    property p_lock;
        s_plain_write |=> interface_lock_off_o == $past(wdata_i[LOCK_OFF_BIT]);
    endproperty
    a_lock: assert property (p_lock) else $error("lock bit wrong");

    property p_readback;
        rd_valid_o |-> !rdata_o[RESERVED_BIT] && !rdata_o[SOFT_RST_BIT];
    endproperty
    a_readback: assert property (p_readback) else $error("reserved bits read set");
endmodule
`default_nettype wire

// ### tb_mcr_config_reg.sv
// self-checking bench for the metering configuration register bank
`timescale 1ns/1ps
`default_nettype none
module tb_mcr_config_reg;
    import mcr_pkg::*;
    localparam int BLINK = 20;
    localparam logic [15:0] OUT_MASK = 16'h8F4F;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [ADDR_W-1:0] addr = 10'h000;
    logic [DATA_W-1:0] wdata = 16'h0000;
    logic p1 = 1'b0;
    logic p2 = 1'b0;
    logic rev = 1'b0;
    logic [3:0] zx = 4'h0; // pos a, neg a, pos b, neg b
    logic [DATA_W-1:0] rdata;
    logic rd_valid, int_a, int_b, hpf, pf_src, zx_off, crc_on, zx_src, lock_off;
    logic srst, rev_out, irq;
    logic [1:0] pwr_t;
    logic [31:0] lf = 32'h0000758B;
    logic [15:0] v;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    int highs;

    mcr_config_reg #(.BLINK_CYC(BLINK)) mcr_config_reg_i (
        .ref_clk_i(ref_clk), .nrst_i(nrst), .ce_i(ce),
        .wr_en_i(wr_en), .rd_en_i(rd_en), .addr_i(addr), .wdata_i(wdata),
        .pulse_output_one_i(p1), .pulse_output_two_i(p2), .reverse_polarity_i(rev),
        .zx_pos_a_i(zx[3]), .zx_neg_a_i(zx[2]), .zx_pos_b_i(zx[1]), .zx_neg_b_i(zx[0]),
        .rdata_o(rdata), .rd_valid_o(rd_valid),
        .integrator_on_chan_a_o(int_a), .integrator_on_chan_b_o(int_b),
        .highpass_on_o(hpf), .power_factor_source_o(pf_src),
        .zero_cross_filter_off_o(zx_off), .checksum_on_o(crc_on),
        .power_filter_time_o(pwr_t), .current_zero_cross_source_o(zx_src),
        .interface_lock_off_o(lock_off), .soft_reset_o(srst),
        .reverse_power_out_o(rev_out), .zero_cross_irq_o(irq)
    );

    always #20 ref_clk = ~ref_clk;

    task automatic print_verdict();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            $display("unexpected at %0t: run too long", $time);
            print_verdict();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // configuration word rebuilt from the level outputs
    function automatic logic [15:0] out_word();
        return {lock_off, 3'h0, zx_src, pwr_t, crc_on, 1'b0, zx_off, 2'h0, pf_src, hpf,
            int_b, int_a};
    endfunction

    function automatic logic exp_irq(input logic [15:0] c, input logic [3:0] z);
        return ((c[ZX_SRC_BIT] ? z[1] : z[3]) && c[13:12] != ZERO_CROSS_EDGE_PICK_NEG_ONLY) ||
            ((c[ZX_SRC_BIT] ? z[0] : z[2]) && c[13:12] != ZERO_CROSS_EDGE_PICK_POS_ONLY);
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge ref_clk);
        wr_en = 1'b0;
    endtask

    task automatic rd(input logic [9:0] a, input logic [15:0] exp);
        addr = a;
        rd_en = 1'b1;
        @(negedge ref_clk);
        rd_en = 1'b0;
        chk_bit(rd_valid, 1'b1, "read valid");
        chk(rdata, exp, "read data");
    endtask

    task automatic pulse(input logic [3:0] z, input logic a, input logic b);
        zx = z;
        p1 = a;
        p2 = b;
        @(negedge ref_clk);
        zx = 4'h0;
        p1 = 1'b0;
        p2 = 1'b0;
    endtask

    initial
    begin
        repeat (4) @(negedge ref_clk);
        nrst = 1'b1;
        @(negedge ref_clk);
        chk(out_word(), CORE_CONFIGURATION_RST & OUT_MASK, "reset levels");
        rd(CORE_CONFIGURATION_ADDR, CORE_CONFIGURATION_RST);
        wr(10'h101, 16'h0003);
        rd(10'h101, UNMAPPED_READ);
        chk(out_word(), CORE_CONFIGURATION_RST & OUT_MASK, "stray write");
        ce = 1'b0;
        wr(CORE_CONFIGURATION_ADDR, 16'h0001);
        ce = 1'b1;
        chk_bit(int_a, 1'b0, "write with clock enable low");
        @(negedge ref_clk);
        wr(CORE_CONFIGURATION_ADDR, 16'hFF7F);
        rd(CORE_CONFIGURATION_ADDR, 16'hBF7F);
        for (int i = 0; i < 80; i++)
        begin
            lf = lfsr(lf);
            v = lf[15:0] & 16'hFF7F;
            wr(CORE_CONFIGURATION_ADDR, v);
            chk(out_word(), v & OUT_MASK, "config levels");
            rd(CORE_CONFIGURATION_ADDR, v & CORE_CONFIGURATION_MASK);
            lf = lfsr(lf);
            pulse(lf[19:16], 1'b0, 1'b0);
            chk_bit(irq, exp_irq(v, lf[19:16]), "crossing irq");
        end
        // reset in mid-run from a non-default configuration
        nrst = 1'b0;
        @(negedge ref_clk);
        nrst = 1'b1;
        @(negedge ref_clk);
        chk(out_word(), CORE_CONFIGURATION_RST & OUT_MASK, "mid-run reset levels");
        chk(rdata, UNMAPPED_READ, "mid-run reset read data");
        chk_bit(irq, 1'b0, "mid-run reset irq");
        wr(CORE_CONFIGURATION_ADDR, 16'h3AFF);
        chk_bit(srst, 1'b1, "soft reset pulse");
        chk(out_word(), CORE_CONFIGURATION_RST & OUT_MASK, "soft reset levels");
        @(negedge ref_clk);
        chk_bit(srst, 1'b0, "soft reset clears");
        rev = 1'b1;
        pulse(4'h0, 1'b0, 1'b1);
        @(negedge ref_clk);
        chk_bit(rev_out, 1'b0, "unpicked pulse");
        pulse(4'h0, 1'b1, 1'b0);
        @(negedge ref_clk);
        chk_bit(rev_out, 1'b1, "reverse level");
        rev = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk_bit(rev_out, 1'b1, "held between pulses");
        wr(CORE_CONFIGURATION_ADDR, 16'h8014);
        pulse(4'h0, 1'b1, 1'b0);
        @(negedge ref_clk);
        chk_bit(rev_out, 1'b1, "second pulse picked");
        pulse(4'h0, 1'b0, 1'b1);
        @(negedge ref_clk);
        chk_bit(rev_out, 1'b0, "forward level");
        rev = 1'b1;
        wr(CORE_CONFIGURATION_ADDR, 16'h8034);
        pulse(4'h0, 1'b0, 1'b1);
        repeat (2) @(negedge ref_clk);
        highs = 0;
        repeat (2 * BLINK)
        begin
            if (rev_out === 1'b1)
                highs++;
            @(negedge ref_clk);
        end
        chk(16'(highs), 16'(BLINK), "blink duty");
        rev = 1'b0;
        pulse(4'h0, 1'b0, 1'b1);
        repeat (2) @(negedge ref_clk);
        chk_bit(rev_out, 1'b0, "blink stops");
        print_verdict();
    end
endmodule
`default_nettype wire
